// File: design/remote_avg16.sv
`timescale 1ns/10ps
`default_nettype none

module remote_avg16
  import temp_readout_pkg::*;
(
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic [10:0] sample,
  input wire logic sample_valid,
  output logic [10:0] avg,
  output logic avg_valid
);

  import temp_readout_pkg::*;

  // ==========================================================================
  // Accumulator
  // ==========================================================================
  logic signed [14:0] acc_r;
  logic [3:0] cnt_r;
  logic signed [14:0] acc_sum;

  // Sign-extend so negative readings average correctly
  assign acc_sum = acc_r + {{4{sample[10]}}, sample};

  // Sixteen samples summed, then divided by a shift (floors toward minus)
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      acc_r <= '0;
      cnt_r <= '0;
      avg <= REMOTE_RST;
      avg_valid <= 1'b0;
    end
    else
    begin
      avg_valid <= 1'b0;
      if (sample_valid)
      begin
        if (cnt_r == AVG_LAST)
        begin
          avg <= acc_sum[AVG_SHIFT +: 11];
          avg_valid <= 1'b1;
          acc_r <= '0;
          cnt_r <= '0;
        end
        else
        begin
          acc_r <= acc_sum;
          cnt_r <= cnt_r + 4'h1;
        end
      end
    end
  end

endmodule

`default_nettype wire

// File: design/temp_readout_smbus_alert.sv
`timescale 1ns/10ps
`default_nettype none

module temp_readout_smbus_alert
  import temp_readout_pkg::*;
#(
  parameter int MEAS_CYCLES_P = MEAS_CYCLES
)
(
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic strap_hi,
  input wire logic strap_lo,
  output logic alert_out,
  output logic alert_oe,
  input wire logic alert_cond,
  input wire logic [9:0] local_raw,
  input wire logic local_valid,
  input wire logic [10:0] remote_sample,
  input wire logic remote_valid,
  output logic sample_req,
  output logic wr_pulse,
  output logic [7:0] reg_ptr,
  output logic [7:0] wr_data,
  output logic [6:0] slave_addr
);

  import temp_readout_pkg::*;

  localparam int SAMPLE_CYCLES = MEAS_CYCLES_P / AVG_SAMPLES;
  localparam int SCW = (SAMPLE_CYCLES > 1) ? $clog2(SAMPLE_CYCLES) : 1;
  localparam logic [SCW-1:0] SAMPLE_LAST = SCW'(SAMPLE_CYCLES - 1);

  // ==========================================================================
  // Decode helpers
  // ==========================================================================
  function automatic logic addr_hit(input logic [7:0] byte_in, input logic [6:0] addr);
    addr_hit = (byte_in[7:1] == addr);
  endfunction

  function automatic logic [7:0] reg_read(
    input logic [7:0] idx,
    input logic [9:0] loc,
    input logic [10:0] rem
  );
    logic [7:0] ext;
    ext = 8'h00;
    ext[LOCAL_FRAC_LSB +: 2] = loc[1:0];
    ext[REMOTE_FRAC_LSB +: 3] = rem[2:0];
    if (idx == IDX_LOCAL_INT)
      reg_read = loc[9:2];
    else if (idx == IDX_REMOTE_INT)
      reg_read = rem[10:3];
    else if (idx == IDX_EXT_FRAC)
      reg_read = ext;
    else
      reg_read = RD_UNMAPPED;
  endfunction

  // ==========================================================================
  // Declarations
  // ==========================================================================
  logic [1:0] scl_sync_r;
  logic [1:0] sda_sync_r;
  logic [1:0] hi_sync_r;
  logic [1:0] lo_sync_r;
  logic scl_prev_r;
  logic sda_prev_r;
  logic scl;
  logic sda;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  logic [1:0] settle_cnt_r;
  logic strap_done_r;
  smb_state_t state_r;
  logic [2:0] bit_cnt_r;
  logic [1:0] byte_cnt_r;
  logic [7:0] shift_in_r;
  logic [7:0] shift_in_nxt;
  logic [7:0] shift_out_r;
  logic [7:0] rd_byte;
  logic ack_drv_r;
  logic rd_mode_r;
  logic ara_mode_r;
  logic ara_done_r;
  logic [9:0] local_r;
  logic [10:0] remote_r;
  logic [10:0] avg_val;
  logic avg_valid;
  logic [SCW-1:0] sample_cnt_r;

  // ==========================================================================
  // Pin synchronisers and bus events
  // ==========================================================================
  // Bus and strap pins are asynchronous, two flops before use
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      scl_sync_r <= 2'h3;
      sda_sync_r <= 2'h3;
      hi_sync_r <= 2'h0;
      lo_sync_r <= 2'h0;
      scl_prev_r <= 1'b1;
      sda_prev_r <= 1'b1;
    end
    else
    begin
      scl_sync_r <= {scl_sync_r[0], scl_in};
      sda_sync_r <= {sda_sync_r[0], sda_in};
      hi_sync_r <= {hi_sync_r[0], strap_hi};
      lo_sync_r <= {lo_sync_r[0], strap_lo};
      scl_prev_r <= scl_sync_r[1];
      sda_prev_r <= sda_sync_r[1];
    end
  end

  assign scl = scl_sync_r[1];
  assign sda = sda_sync_r[1];
  assign scl_rise = scl & ~scl_prev_r;
  assign scl_fall = ~scl & scl_prev_r;
  assign start_det = scl & scl_prev_r & sda_prev_r & ~sda;
  assign stop_det = scl & scl_prev_r & ~sda_prev_r & sda;
  assign shift_in_nxt = {shift_in_r[6:0], sda};

  // ==========================================================================
  // Address strap
  // ==========================================================================
  // Caught once after the synchroniser settles; later strap moves are ignored
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      settle_cnt_r <= 2'h0;
      strap_done_r <= 1'b0;
      slave_addr <= {ADDR_UPPER, STRAP_GND};
    end
    else if (!strap_done_r)
    begin
      if (settle_cnt_r == STRAP_SETTLE)
      begin
        strap_done_r <= 1'b1;
        if (hi_sync_r[1])
          slave_addr <= {ADDR_UPPER, STRAP_VCC};
        else if (lo_sync_r[1])
          slave_addr <= {ADDR_UPPER, STRAP_GND};
        else
          slave_addr <= {ADDR_UPPER, STRAP_OPEN};
      end
      else
        settle_cnt_r <= settle_cnt_r + 2'h1;
    end
  end

  // ==========================================================================
  // Slave transaction engine
  // ==========================================================================
  // Byte handed out on a read: own address for an alert query, else register
  assign rd_byte = ara_mode_r ? {slave_addr, 1'b0} : reg_read(reg_ptr, local_r, remote_r);

  // Acts on synchronised edges; the line is only ever pulled low, never driven high
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state_r <= ST_IDLE;
      bit_cnt_r <= 3'h0;
      byte_cnt_r <= 2'h0;
      shift_in_r <= 8'h00;
      shift_out_r <= 8'h00;
      ack_drv_r <= 1'b0;
      rd_mode_r <= 1'b0;
      ara_mode_r <= 1'b0;
      ara_done_r <= 1'b0;
      sda_oe <= 1'b0;
      reg_ptr <= PTR_RST;
      wr_data <= 8'h00;
      wr_pulse <= 1'b0;
    end
    else
    begin
      wr_pulse <= 1'b0;
      ara_done_r <= 1'b0;
      if (start_det)
      begin
        // Repeated start keeps the pointer, giving Read Byte for free
        state_r <= ST_ADDR;
        bit_cnt_r <= 3'h0;
        sda_oe <= 1'b0;
      end
      else if (stop_det)
      begin
        state_r <= ST_IDLE;
        sda_oe <= 1'b0;
      end
      else
      begin
        case (state_r)
          ST_ADDR:
            if (scl_rise)
            begin
              shift_in_r <= shift_in_nxt;
              bit_cnt_r <= bit_cnt_r + 3'h1;
              if (bit_cnt_r == 3'h7)
              begin
                byte_cnt_r <= 2'h0;
                ack_drv_r <= 1'b0;
                rd_mode_r <= sda;
                ara_mode_r <= 1'b0;
                if (strap_done_r && addr_hit(shift_in_nxt, slave_addr))
                  state_r <= ST_ACK_ADDR;
                else if (sda && alert_oe && addr_hit(shift_in_nxt, ARA_ADDR))
                begin
                  ara_mode_r <= 1'b1;
                  state_r <= ST_ACK_ADDR;
                end
                else
                  state_r <= ST_IDLE;
              end
            end
          ST_ACK_ADDR:
            if (scl_fall)
            begin
              if (!ack_drv_r)
              begin
                sda_oe <= 1'b1;
                ack_drv_r <= 1'b1;
              end
              else if (rd_mode_r)
              begin
                // Read uses whatever the pointer already holds
                shift_out_r <= rd_byte;
                sda_oe <= ~rd_byte[7];
                ack_drv_r <= 1'b0;
                state_r <= ST_RD;
              end
              else
              begin
                sda_oe <= 1'b0;
                ack_drv_r <= 1'b0;
                state_r <= ST_WR;
              end
            end
          ST_WR:
            if (scl_rise)
            begin
              shift_in_r <= shift_in_nxt;
              bit_cnt_r <= bit_cnt_r + 3'h1;
              if (bit_cnt_r == 3'h7)
              begin
                byte_cnt_r <= byte_cnt_r + 2'h1;
                if (byte_cnt_r == 2'h0)
                begin
                  reg_ptr <= shift_in_nxt;
                  state_r <= ST_ACK_WR;
                end
                else if (byte_cnt_r == 2'h1)
                begin
                  wr_data <= shift_in_nxt;
                  wr_pulse <= 1'b1;
                  state_r <= ST_ACK_WR;
                end
                else
                  state_r <= ST_IDLE;
              end
            end
          ST_ACK_WR:
            if (scl_fall)
            begin
              sda_oe <= ~ack_drv_r;
              ack_drv_r <= ~ack_drv_r;
              if (ack_drv_r)
                state_r <= ST_WR;
            end
          ST_RD:
            if (scl_rise)
            begin
              // Released a one but line is low: another device won
              if (!sda_oe && !sda)
                state_r <= ST_IDLE;
              else
              begin
                bit_cnt_r <= bit_cnt_r + 3'h1;
                if (bit_cnt_r == 3'h7)
                begin
                  state_r <= ST_ACK_RD;
                  ara_done_r <= ara_mode_r;
                end
              end
            end
            else if (scl_fall)
            begin
              shift_out_r <= {shift_out_r[6:0], 1'b0};
              sda_oe <= ~shift_out_r[6];
            end
          ST_ACK_RD:
            if (scl_fall)
              sda_oe <= 1'b0;
            else if (scl_rise)
              state_r <= ST_IDLE;
          default:
            sda_oe <= 1'b0;
        endcase
      end
    end
  end

  // Open-drain pins: data level is always low, the enable does the work
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      sda_out <= 1'b0;
      alert_out <= 1'b0;
    end
    else
    begin
      sda_out <= 1'b0;
      alert_out <= 1'b0;
    end
  end

  // ==========================================================================
  // Alert line
  // ==========================================================================
  // New set beats the answer's clear so a fresh cause is never lost
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      alert_oe <= 1'b0;
    else if (avg_valid && alert_cond)
      alert_oe <= 1'b1;
    else if (ara_done_r)
      alert_oe <= 1'b0;
  end

  // ==========================================================================
  // Conversion pacing
  // ==========================================================================
  // Sixteen requests per measurement period
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      sample_cnt_r <= '0;
      sample_req <= 1'b0;
    end
    else
    begin
      sample_req <= 1'b0;
      if (sample_cnt_r == SAMPLE_LAST)
      begin
        sample_cnt_r <= '0;
        sample_req <= 1'b1;
      end
      else
        sample_cnt_r <= sample_cnt_r + 1'b1;
    end
  end

  remote_avg16 u_avg (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .sample(remote_sample),
    .sample_valid(remote_valid),
    .avg(avg_val),
    .avg_valid(avg_valid)
  );

  // ==========================================================================
  // Result registers
  // ==========================================================================
  // Whole words kept so integer and fraction bytes always match
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      local_r <= LOCAL_RST;
      remote_r <= REMOTE_RST;
    end
    else
    begin
      if (local_valid)
        local_r <= local_raw;
      if (avg_valid)
        remote_r <= avg_val;
    end
  end

endmodule

`default_nettype wire

// File: shared/temp_readout_pkg.sv
package temp_readout_pkg;

  // ==========================================================================
  // Bus addressing
  // ==========================================================================
  localparam logic [4:0] ADDR_UPPER = 5'h0b;   // Fixed upper five address bits
  localparam logic [6:0] ARA_ADDR = 7'h0c;     // Alert Response Address
  localparam logic [1:0] STRAP_GND = 2'h0;     // Strap tied low
  localparam logic [1:0] STRAP_OPEN = 2'h2;    // Strap left open
  localparam logic [1:0] STRAP_VCC = 2'h1;     // Strap tied high
  localparam logic [1:0] STRAP_SETTLE = 2'h3;  // Cycles before strap is caught

  // ==========================================================================
  // Register indices and fields
  // ==========================================================================
  localparam logic [7:0] IDX_EXT_FRAC = 8'h06;
  localparam logic [7:0] IDX_LOCAL_INT = 8'h0a;
  localparam logic [7:0] IDX_REMOTE_INT = 8'h0b;
  localparam int LOCAL_FRAC_LSB = 6;
  localparam int REMOTE_FRAC_LSB = 0;
  localparam logic [7:0] RD_UNMAPPED = 8'h00;
  localparam logic [7:0] PTR_RST = 8'h00;
  localparam logic [9:0] LOCAL_RST = 10'h000;
  localparam logic [10:0] REMOTE_RST = 11'h000;

  // ==========================================================================
  // Conversion timing
  // ==========================================================================
  localparam int CLK_MHZ = 50;
  localparam int MEAS_TIME_US = 9600;
  localparam int MEAS_CYCLES = MEAS_TIME_US * CLK_MHZ;
  localparam int AVG_SAMPLES = 16;
  localparam int AVG_SHIFT = 4;
  localparam logic [3:0] AVG_LAST = 4'hf;

  // ==========================================================================
  // Slave state machine
  // ==========================================================================
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_ACK_ADDR,
    ST_WR,
    ST_ACK_WR,
    ST_RD,
    ST_ACK_RD
  } smb_state_t;

endpackage

// File: verif/smb_host.sv
`timescale 1ns/10ps
`default_nettype none

// ============================================================
// Bus master model; line has a pull-up, so a wired-and
module smb_host
(
  input wire logic ref_clk,
  input wire logic sda_oe,
  output logic scl,
  output logic sda
);
  logic sda_drv;
  assign sda = sda_drv & ~sda_oe;
  initial
  begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end

  task automatic hold(input int n);
    repeat (n) @(negedge ref_clk);
  endtask

  // Data moves only while the clock is low; ten cycles per phase
  task automatic bit_cyc(input logic b, output logic r);
    sda_drv = b;
    hold(10);
    scl = 1'b1;
    hold(5);
    r = sda;
    hold(5);
    scl = 1'b0;
  endtask

  // Also serves as repeated start
  task automatic start();
    sda_drv = 1'b1;
    hold(10);
    scl = 1'b1;
    hold(10);
    sda_drv = 1'b0;
    hold(10);
    scl = 1'b0;
  endtask

  task automatic stop();
    sda_drv = 1'b0;
    hold(10);
    scl = 1'b1;
    hold(10);
    sda_drv = 1'b1;
    hold(10);
  endtask

  task automatic wbyte(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_cyc(b[i], r);
    bit_cyc(1'b1, r);
    ack = ~r;
  endtask

  // drv below 8'hff plays a rival answering at the same time
  task automatic rbyte(input logic [7:0] drv, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_cyc(drv[i], d[i]);
    bit_cyc(1'b1, r);
  endtask
endmodule

`default_nettype wire

// File: verif/temp_readout_chk.sv
`timescale 1ns/10ps
`default_nettype none

// ============================================================
// Port checker for the readout block
module temp_readout_chk
  import temp_readout_pkg::*;
#(
  parameter int MEAS_CYCLES_P = MEAS_CYCLES
)
(
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic scl_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic alert_out,
  input wire logic alert_oe,
  input wire logic alert_cond,
  input wire logic sample_req,
  input wire logic wr_pulse,
  input wire logic [7:0] reg_ptr,
  input wire logic [6:0] slave_addr
);
  localparam int SPAN = MEAS_CYCLES_P / AVG_SAMPLES;
  logic [15:0] gap_r;
  logic seen_r;
  logic [3:0] up_r;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  // Cycles since the last sample request, and since reset release
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      gap_r <= '0;
      seen_r <= 1'b0;
      up_r <= '0;
    end
    else
    begin
      gap_r <= sample_req ? 16'h0000 : gap_r + 16'h0001;
      seen_r <= seen_r | sample_req;
      up_r <= (up_r == 4'hf) ? up_r : up_r + 4'h1;
    end
  end

  chk_open_drain: assert property (!sda_out && !alert_out)
    else $error("pin drives a high level");
  chk_addr_upper: assert property (slave_addr[6:2] == ADDR_UPPER)
    else $error("upper address bits wrong");
  chk_addr_frozen: assert property (up_r == 4'hf |-> $stable(slave_addr))
    else $error("own address moved after power-up");
  chk_wr_single: assert property (wr_pulse |=> !wr_pulse)
    else $error("write pulse longer than one cycle");
  chk_ptr_keep: assert property (wr_pulse |-> $stable(reg_ptr))
    else $error("data byte changed the pointer");
  chk_sample_period: assert property (sample_req && seen_r |-> gap_r == SPAN - 1)
    else $error("sample request spacing wrong");
  chk_sample_due: assert property (gap_r <= SPAN + 1)
    else $error("sample request missing");
  chk_alert_cause: assert property ($rose(alert_oe) |->
    $past(alert_cond) || $past(alert_cond, 2))
    else $error("alert raised without cause");
  chk_alert_clear: assert property ($fell(alert_oe) |-> $past(sda_oe))
    else $error("alert released outside an answer");
  chk_data_scl_low: assert property ($changed(sda_oe) |-> !scl_in)
    else $error("data line moved while clock high");
endmodule

bind temp_readout_smbus_alert temp_readout_chk #(.MEAS_CYCLES_P(MEAS_CYCLES_P)) u_chk (
  .ref_clk, .nrst, .scl_in, .sda_out, .sda_oe, .alert_out, .alert_oe, .alert_cond,
  .sample_req, .wr_pulse, .reg_ptr, .slave_addr);

`default_nettype wire

// File: verif/temp_readout_smbus_alert_tb.sv
`timescale 1ns/10ps
`default_nettype none

// ============================================================
// Register, averaging and alert tests through the bus model
module temp_readout_smbus_alert_tb;
  import temp_readout_pkg::*;
  localparam logic [6:0] SA = {ADDR_UPPER, STRAP_OPEN};
  logic ref_clk, nrst, strap_hi, strap_lo, alert_cond, local_valid;
  logic remote_valid = 1'b0;
  logic [9:0] local_raw;
  logic [10:0] remote_sample = 11'h000;
  wire logic scl, sda, sda_out, sda_oe, alert_out, alert_oe, sample_req, wr_pulse;
  wire logic [7:0] reg_ptr, wr_data;
  wire logic [6:0] slave_addr;
  logic [7:0] d;
  logic a;
  int feed = 0;
  int n_fed = 0;
  int n_wr = 0;
  int n_mismatch = 0;
  int checks = 0;

  temp_readout_smbus_alert #(.MEAS_CYCLES_P(160)) dut (.ref_clk(ref_clk), .nrst(nrst),
    .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe), .strap_hi(strap_hi),
    .strap_lo(strap_lo), .alert_out(alert_out), .alert_oe(alert_oe), .alert_cond(alert_cond),
    .local_raw(local_raw), .local_valid(local_valid), .remote_sample(remote_sample),
    .remote_valid(remote_valid), .sample_req(sample_req), .wr_pulse(wr_pulse),
    .reg_ptr(reg_ptr), .wr_data(wr_data), .slave_addr(slave_addr));
  smb_host host (.ref_clk(ref_clk), .sda_oe(sda_oe), .scl(scl), .sda(sda));

  initial
  begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  // Front end answers sample requests while feed is non-zero
  always @(negedge ref_clk)
  begin
    if (remote_valid)
      remote_valid = 1'b0;
    else if (sample_req === 1'b1 && feed > 0)
    begin
      remote_sample = n_fed[0] ? 11'h0ce : 11'h0cc;
      remote_valid = 1'b1;
      n_fed++;
      feed--;
    end
  end

  always @(posedge ref_clk) if (wr_pulse === 1'b1) n_wr++;

  task automatic check_val(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic check_flag(input logic got, input logic exp);
    check_val({7'h00, got}, {7'h00, exp});
  endtask

  // Write transaction of n bytes: pointer first, then data
  task automatic wr(input logic [7:0] p, input logic [7:0] v, input int n, output logic ack);
    host.start();
    host.wbyte({SA, 1'b0}, ack);
    for (int k = 0; k < n; k++) host.wbyte(k == 0 ? p : v, ack);
    host.stop();
  endtask

  // Single-byte read at any address; no ack gives 8'h00
  task automatic rd(input logic [6:0] ad, input logic [7:0] drv,
    output logic ack, output logic [7:0] v);
    host.start();
    host.wbyte({ad, 1'b1}, ack);
    v = 8'h00;
    if (ack) host.rbyte(drv, v);
    host.stop();
  endtask

  // Read Byte: pointer write, repeated start, read
  task automatic rd_byte(input logic [7:0] p, output logic [7:0] v);
    logic ack;
    host.start();
    host.wbyte({SA, 1'b0}, ack);
    host.wbyte(p, ack);
    host.start();
    host.wbyte({SA, 1'b1}, ack);
    host.rbyte(8'hff, v);
    host.stop();
  endtask

  task automatic run_feed(input int n);
    feed = n;
    repeat (400) if (feed != 0) @(negedge ref_clk);
    repeat (4) @(negedge ref_clk);
  endtask

  // Mid-run reset; the strap must already stand at its new level
  task automatic pulse_reset();
    nrst = 1'b0;
    repeat (3) @(negedge ref_clk);
    nrst = 1'b1;
    repeat (10) @(negedge ref_clk);
  endtask

  task automatic report_and_stop();
    $display("checks %0d n_mismatch %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  initial
  begin
    repeat (60000) @(posedge ref_clk);
    n_mismatch++;
    report_and_stop();
  end

  initial
  begin
    {nrst, strap_hi, strap_lo, alert_cond, local_valid} = '0;
    local_raw = '0;
    repeat (12) @(negedge ref_clk);
    nrst = 1'b1;
    repeat (10) @(negedge ref_clk);
    check_val({1'b0, slave_addr}, {1'b0, SA});
    check_val(reg_ptr, PTR_RST);
    strap_hi = 1'b1;
    rd(SA, 8'hff, a, d);
    check_flag(a, 1'b1);
    check_val(d, RD_UNMAPPED);
    rd(7'h2f, 8'hff, a, d);
    check_flag(a, 1'b0);
    wr(IDX_EXT_FRAC, 8'h00, 1, a);
    check_flag(a, 1'b1);
    check_val(reg_ptr, IDX_EXT_FRAC);
    check_val(n_wr[7:0], 8'h00);
    wr(IDX_LOCAL_INT, 8'h5a, 2, a);
    check_flag(a, 1'b1);
    check_val(reg_ptr, IDX_LOCAL_INT);
    check_val(wr_data, 8'h5a);
    check_val(n_wr[7:0], 8'h01);
    wr(IDX_REMOTE_INT, 8'h33, 3, a);
    check_flag(a, 1'b0);
    check_val(reg_ptr, IDX_REMOTE_INT);
    check_val(n_wr[7:0], 8'h02);
    // Minus 24.75 degrees: integer byte is the floor, -25
    @(negedge ref_clk);
    local_raw = 10'h39d;
    local_valid = 1'b1;
    @(negedge ref_clk);
    local_valid = 1'b0;
    rd_byte(IDX_LOCAL_INT, d);
    check_val(d, 8'he7);
    rd(SA, 8'hff, a, d);
    check_val(d, 8'he7);
    // Fifteen samples must not yet reach the result
    run_feed(15);
    rd_byte(IDX_REMOTE_INT, d);
    check_val(d, 8'h00);
    alert_cond = 1'b1;
    run_feed(1);
    alert_cond = 1'b0;
    check_flag(alert_oe, 1'b1);
    rd_byte(IDX_EXT_FRAC, d);
    check_val(d, 8'h45);
    rd_byte(IDX_REMOTE_INT, d);
    check_val(d, 8'h19);
    // Lower-addressed rival wins the alert answer
    rd(ARA_ADDR, 8'h00, a, d);
    check_flag(a, 1'b1);
    check_flag(alert_oe, 1'b1);
    rd(ARA_ADDR, 8'hff, a, d);
    check_flag(a, 1'b1);
    check_val(d, {SA, 1'b0});
    check_flag(alert_oe, 1'b0);
    rd(ARA_ADDR, 8'hff, a, d);
    check_flag(a, 1'b0);
    alert_cond = 1'b1;
    run_feed(16);
    check_flag(alert_oe, 1'b1);
    // Strap tied high after the address was caught only counts after a new reset
    pulse_reset();
    check_val({1'b0, slave_addr}, {1'b0, ADDR_UPPER, STRAP_VCC});
    rd({ADDR_UPPER, STRAP_VCC}, 8'hff, a, d);
    check_flag(a, 1'b1);
    check_val(d, RD_UNMAPPED);
    {strap_hi, strap_lo} = 2'h1;
    pulse_reset();
    check_val({1'b0, slave_addr}, {1'b0, ADDR_UPPER, STRAP_GND});
    rd(SA, 8'hff, a, d);
    check_flag(a, 1'b0);
    report_and_stop();
  end
endmodule

`default_nettype wire
